// ---- pll_clock_multiplier_config.sv ----
// Loop configuration registers, reference selection and pre-division
// Functional notes
// - Source bit picks internal or external
// - Internal divide factor feeds loop only when internal source is selected
// - Reference divided by five-bit pre-divider
// - Loop multiplies by multiplier register value
// - Lock flag rises when loop is stable
`timescale 1ns/1ps
`include "pll_defs.svh"
module pll_clock_multiplier_config
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic [7:0] sfrWdata,
  input  wire logic       sfrRead,
  output logic      [7:0] sfrRdata,
  input  wire logic       intOscClkIn,
  input  wire logic       extOscClkIn,
  input  wire logic       loopLockIn,
  output logic            refSourceSelect,
  output logic      [4:0] predivValue,
  output logic      [7:0] multiplierValue,
  output logic      [1:0] oscRangeField,
  output logic      [3:0] loopFilterField,
  output logic            divRefTick,
  output logic            lockFlag
);

  pll_lock_if lockBus ();

  logic [2:0] syncA;             // First synchroniser stage
  logic [2:0] syncB;             // Second stage, the only one logic reads
  logic [1:0] edgeHist;          // Previous clock levels for edge detection
  logic [7:0] loopControl;       // Source select held here
  logic [7:0] next_loopControl;
  logic [7:0] intOscControl;     // Internal oscillator divide field
  logic [7:0] next_intOscControl;
  logic [7:0] predivReg;
  logic [7:0] next_predivReg;
  logic [7:0] multiplierReg;
  logic [7:0] next_multiplierReg;
  logic [7:0] filterConfig;
  logic [7:0] next_filterConfig;
  logic [7:0] next_sfrRdata;
  logic [2:0] intDivCount;       // Internal oscillator divide counter
  logic [2:0] next_intDivCount;
  logic [4:0] predivCount;       // Pre-divider counter
  logic [4:0] next_predivCount;
  logic       next_divRefTick;
  logic       cfgChange;         // Registered change pulse to the monitor
  logic       next_cfgChange;
  logic       intEdge;
  logic       extEdge;
  logic       refEdge;
  logic       intTick;

  // Register address match, used by both write and read paths
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
    hits = (addr == target);
  endfunction

  // Pins come from other domains: two flops before anything reads them
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      syncA    <= 3'h0;
      syncB    <= 3'h0;
      edgeHist <= 2'h0;
    end
    else
    begin
      syncA    <= {loopLockIn, extOscClkIn, intOscClkIn};
      syncB    <= syncA;
      edgeHist <= syncB[1:0];
    end
  end

  // Rising edges of the sampled oscillators; they must run below clk/2
  assign intEdge = syncB[0] & ~edgeHist[0];
  assign extEdge = syncB[1] & ~edgeHist[1];
  // Internal path: divide by 2 to the power of the divide field
  assign intTick = intEdge &
                   (intDivCount == 3'((1 << intOscControl[`INT_OSC_DIV_MSB:`INT_OSC_DIV_LSB]) - 1));
  assign refEdge = loopControl[`REF_SOURCE_BIT] ? extEdge : intTick;

  // Register write next values
  always_comb
  begin
    next_loopControl   = loopControl;
    next_intOscControl = intOscControl;
    next_predivReg     = predivReg;
    next_multiplierReg = multiplierReg;
    next_filterConfig  = filterConfig;
    next_cfgChange     = 1'b0;
    if (sfrWrite)
    begin
      if (hits(sfrAddr, `LOOP_CONTROL_ADDR))
      begin
        next_loopControl = 8'h00;
        next_loopControl[`REF_SOURCE_BIT] = sfrWdata[`REF_SOURCE_BIT];
        next_cfgChange = sfrWdata[`REF_SOURCE_BIT] != loopControl[`REF_SOURCE_BIT];
      end
      if (hits(sfrAddr, `INT_OSC_CONTROL_ADDR))
        next_intOscControl = {6'h00, sfrWdata[`INT_OSC_DIV_MSB:`INT_OSC_DIV_LSB]};
      if (hits(sfrAddr, `PREDIV_ADDR))
      begin
        next_predivReg = {3'h0, sfrWdata[`PREDIV_MSB:0]};
        next_cfgChange = 1'b1;
      end
      if (hits(sfrAddr, `MULTIPLIER_ADDR))
      begin
        next_multiplierReg = sfrWdata;
        next_cfgChange     = 1'b1;
      end
      // Top two bits are not stored, so they always read zero
      if (hits(sfrAddr, `LOOP_FILTER_CONFIG_ADDR))
        next_filterConfig = {2'h0, sfrWdata[`RANGE_FIELD_MSB:0]};
    end
  end

  // Read data: captured when sfrRead is high, unmapped reads give zero
  always_comb
  begin
    next_sfrRdata = sfrRdata;
    if (sfrRead)
    begin
      next_sfrRdata = `READ_ZERO;
      if (hits(sfrAddr, `LOOP_CONTROL_ADDR))
      begin
        next_sfrRdata = loopControl;
        next_sfrRdata[`LOCK_FLAG_BIT] = lockBus.lockFlag;
      end
      if (hits(sfrAddr, `INT_OSC_CONTROL_ADDR))
        next_sfrRdata = intOscControl;
      if (hits(sfrAddr, `PREDIV_ADDR))
        next_sfrRdata = predivReg;
      if (hits(sfrAddr, `MULTIPLIER_ADDR))
        next_sfrRdata = multiplierReg;
      if (hits(sfrAddr, `LOOP_FILTER_CONFIG_ADDR))
        next_sfrRdata = filterConfig;
    end
  end

  // Reference divider counters; restarted by a change so phase is clean
  always_comb
  begin
    next_intDivCount = intDivCount;
    next_predivCount = predivCount;
    next_divRefTick  = 1'b0;
    if (intEdge)
      next_intDivCount = intTick ? 3'h0 : intDivCount + 3'h1;
    // A pre-divider of zero wraps to 31 below and so divides by 32
    if (refEdge)
    begin
      if (predivCount == predivReg[`PREDIV_MSB:0] - 5'h01)
      begin
        next_predivCount = 5'h00;
        next_divRefTick  = 1'b1;
      end
      else
        next_predivCount = predivCount + 5'h01;
    end
    if (cfgChange)
    begin
      next_intDivCount = 3'h0;
      next_predivCount = 5'h00;
    end
  end

  // All registers of the block except the synchroniser and edge-history flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      loopControl   <= `LOOP_CONTROL_RST;
      intOscControl <= `INT_OSC_CONTROL_RST;
      predivReg     <= `PREDIV_RST;
      multiplierReg <= `MULTIPLIER_RST;
      filterConfig  <= `LOOP_FILTER_CONFIG_RST;
      sfrRdata      <= `READ_ZERO;
      cfgChange     <= 1'b0;
      intDivCount   <= 3'h0;
      predivCount   <= 5'h00;
      divRefTick    <= 1'b0;
    end
    else
    begin
      loopControl   <= next_loopControl;
      intOscControl <= next_intOscControl;
      predivReg     <= next_predivReg;
      multiplierReg <= next_multiplierReg;
      filterConfig  <= next_filterConfig;
      sfrRdata      <= next_sfrRdata;
      cfgChange     <= next_cfgChange;
      intDivCount   <= next_intDivCount;
      predivCount   <= next_predivCount;
      divRefTick    <= next_divRefTick;
    end
  end

  // Field outputs to the analog loop
  assign refSourceSelect = loopControl[`REF_SOURCE_BIT];
  assign predivValue     = predivReg[`PREDIV_MSB:0];
  assign multiplierValue = multiplierReg;
  assign oscRangeField   = filterConfig[`RANGE_FIELD_MSB:`RANGE_FIELD_LSB];
  assign loopFilterField = filterConfig[`FILTER_FIELD_MSB:0];
  assign lockFlag        = lockBus.lockFlag;
  assign lockBus.cfgChange = cfgChange;
  assign lockBus.rawLock   = syncB[2];

  pll_lock_monitor lockMon
  (
    .clk     (clk),
    .reset   (reset),
    .lockBus (lockBus.monitor_side)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence multWrite;
    sfrWrite && hits(sfrAddr, `MULTIPLIER_ADDR);
  endsequence

  source_select_a: assert property (sfrWrite && hits(sfrAddr, `LOOP_CONTROL_ADDR) |=>
    refSourceSelect == $past(sfrWdata[`REF_SOURCE_BIT]))
    else $error("source select not taken from write");
  int_divide_a: assert property (!refSourceSelect && intEdge && intDivCount == 3'h0 &&
    intOscControl[1:0] == 2'h1 |-> !refEdge)
    else $error("internal divide factor not applied");
  prediv_tick_a: assert property (divRefTick |-> $past(refEdge))
    else $error("divided tick without reference edge");
  mult_value_a: assert property (multWrite |=> multiplierValue == $past(sfrWdata))
    else $error("multiplier value not presented");
  lock_rise_a: assert property ($rose(lockFlag) |-> $past(syncB[2], 2))
    else $error("lock flag rose without raw lock");
  lock_clear_a: assert property (multWrite |-> ##2 !lockFlag)
    else $error("lock flag not cleared by change");
  // Any restart pulse, whichever register caused it, drops the flag next edge
  cfg_restart_a: assert property (cfgChange |=> !lockFlag)
    else $error("lock flag kept after config change");

  sequence filterWrite;
    sfrWrite && hits(sfrAddr, `LOOP_FILTER_CONFIG_ADDR);
  endsequence

  // A write keeps the six low bits and forces the unused pair to zero
  filter_top_a: assert property (filterWrite |=>
    filterConfig == {2'h0, $past(sfrWdata[`RANGE_FIELD_MSB:0])})
    else $error("filter write not stored with top bits zero");
  // Compare with the fields before the read edge, so a write in the same
  // cycle does not leak into the returned byte
  filter_read_a: assert property (sfrRead && hits(sfrAddr, `LOOP_FILTER_CONFIG_ADDR) |=>
    sfrRdata == $past({2'h0, oscRangeField, loopFilterField}))
    else $error("filter read data mismatch");

endmodule

// ---- pll_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the loop configuration
`ifndef PLL_DEFS_SVH
`define PLL_DEFS_SVH

// Register offsets
`define LOOP_FILTER_CONFIG_ADDR  8'h8F
`define LOOP_CONTROL_ADDR        8'h8B
`define INT_OSC_CONTROL_ADDR     8'h8A
`define PREDIV_ADDR              8'h8C
`define MULTIPLIER_ADDR          8'h8D

// Field positions
`define REF_SOURCE_BIT           2
`define LOCK_FLAG_BIT            5
`define INT_OSC_DIV_LSB          0
`define INT_OSC_DIV_MSB          1
`define PREDIV_MSB               4
`define FILTER_FIELD_MSB         3
`define RANGE_FIELD_LSB          4
`define RANGE_FIELD_MSB          5

// Reset values
`define LOOP_FILTER_CONFIG_RST   8'h31
`define LOOP_CONTROL_RST         8'h00
`define INT_OSC_CONTROL_RST      8'h00
`define PREDIV_RST               8'h01
`define MULTIPLIER_RST           8'h01
`define READ_ZERO                8'h00

// Timing: settle time after raw lock before the flag rises
`define LOCK_SETTLE_NS           1000
`define CLK_PERIOD_NS            10
`define LOCK_SETTLE_CYCLES       ((`LOCK_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- pll_pkg.sv ----
// Types shared by the loop configuration block
package pll_pkg;

  // Lock monitor states
  typedef enum logic [1:0] {
    UNLOCKED,
    SETTLING,
    LOCKED
  } lock_state_t;

  typedef logic [7:0] sfr_byte_t;

endpackage

// ---- pll_lock_if.sv ----
// Carrier between the configuration registers and the lock monitor
`timescale 1ns/1ps
interface pll_lock_if;
  logic cfgChange;   // Pulse: source changed, or pre-divider or multiplier written
  logic rawLock;     // Synchronised lock level from the analog loop
  logic lockFlag;    // Settled lock status

  modport config_side  (output cfgChange, output rawLock, input lockFlag);
  modport monitor_side (input cfgChange, input rawLock, output lockFlag);
endinterface

// ---- pll_lock_monitor.sv ----
// Lock monitor: qualifies the analog lock level into a settled lock flag
`timescale 1ns/1ps
`include "pll_defs.svh"
module pll_lock_monitor
(
  input  wire logic        clk,
  input  wire logic        reset,
  pll_lock_if.monitor_side lockBus
);

  localparam int SETTLE = `LOCK_SETTLE_CYCLES;

  pll_pkg::lock_state_t state;        // Current monitor state
  pll_pkg::lock_state_t next_state;
  logic [7:0]           settleCount;  // Cycles of steady raw lock
  logic [7:0]           next_settleCount;
  logic                 lockFlag;
  logic                 next_lockFlag;

  // Next state: any config change restarts acquisition, and wins over a
  // lock that arrives the same cycle so stale lock is never reported
  always_comb
  begin
    next_state       = state;
    next_settleCount = settleCount;
    next_lockFlag    = 1'b0;
    if (lockBus.cfgChange)
    begin
      next_state       = pll_pkg::UNLOCKED;
      next_settleCount = 8'h00;
    end
    else
    begin
      unique case (state)
        pll_pkg::UNLOCKED:
        begin
          next_settleCount = 8'h00;
          if (lockBus.rawLock)
            next_state = pll_pkg::SETTLING;
        end
        pll_pkg::SETTLING:
        begin
          // Any dropout restarts the settle time
          if (!lockBus.rawLock)
            next_state = pll_pkg::UNLOCKED;
          else if (settleCount == 8'(SETTLE - 1))
            next_state = pll_pkg::LOCKED;
          else
            next_settleCount = settleCount + 8'h01;
        end
        pll_pkg::LOCKED:
        begin
          if (!lockBus.rawLock)
            next_state = pll_pkg::UNLOCKED;
        end
        default:
          next_state = pll_pkg::UNLOCKED;
      endcase
    end
    next_lockFlag = (next_state == pll_pkg::LOCKED);
  end

  // State registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state       <= pll_pkg::UNLOCKED;
      settleCount <= 8'h00;
      lockFlag    <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      settleCount <= next_settleCount;
      lockFlag    <= next_lockFlag;
    end
  end

  assign lockBus.lockFlag = lockFlag;

endmodule

// ---- test_pll_clock_multiplier_config.sv ----
// Self-checking bench for the loop configuration registers, reference path and lock flag
`timescale 1ns/1ps
`include "pll_defs.svh"
module test_pll_clock_multiplier_config;
  logic       clk;             // 100 MHz system clock
  logic       reset;           // Asynchronous, active high
  logic [7:0] sfrAddr;         // Register address
  logic       sfrWrite;        // Write strobe
  logic [7:0] sfrWdata;        // Write data
  logic       sfrRead;         // Read strobe
  logic [7:0] sfrRdata;        // Registered read data
  logic       intOscClkIn;     // Internal oscillator level
  logic       extOscClkIn;     // External oscillator level
  logic       loopLockIn;      // Raw lock from the analog loop
  logic       refSourceSelect; // Selected reference
  logic [4:0] predivValue;     // Pre-divider field
  logic [7:0] multiplierValue; // Multiplier field
  logic [1:0] oscRangeField;   // Oscillator range field
  logic [3:0] loopFilterField; // Loop filter field
  logic       divRefTick;      // Divided reference pulse
  logic       lockFlag;        // Settled lock
  int         errors;          // Mismatch count
  int         nTests;          // Comparison count
  int         ticks;           // Divided reference pulses seen
  int         base;            // Pulse count at start of a burst
  int         cycles;          // Hang guard
  logic [3:0] filterCodes [4] = '{4'h1, 4'h3, 4'h7, 4'hF}; // One code per range step

  pll_clock_multiplier_config DUT
  (
    .clk(clk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
    .intOscClkIn(intOscClkIn), .extOscClkIn(extOscClkIn), .loopLockIn(loopLockIn),
    .refSourceSelect(refSourceSelect), .predivValue(predivValue),
    .multiplierValue(multiplierValue), .oscRangeField(oscRangeField),
    .loopFilterField(loopFilterField), .divRefTick(divRefTick), .lockFlag(lockFlag)
  );

  // Free-running clock
  always #5 clk = ~clk;

  // Pulse counter and hang guard; a run of about 1400 cycles is expected
  always @(posedge clk)
  begin
    cycles++;
    if (divRefTick === 1'b1)
      ticks++;
    if (cycles == 6000)
    begin
      errors++;
      give_verdict;
    end
  end

  task give_verdict;
    if (errors == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Single comparison kind: narrower values are zero-extended by the caller
  task checkVal(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write strobe; returns at the edge that takes it
  task wrReg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    sfrAddr  <= addr;
    sfrWdata <= data;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
    #1;
  endtask

  // One read strobe, data compared once it has been registered
  task readCheck(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    sfrAddr <= addr;
    sfrRead <= 1'b1;
    @(posedge clk);
    sfrRead <= 1'b0;
    #1 checkVal(sfrRdata, exp);
  endtask

  // Oscillator edges at one per 8 clocks, slow enough for the synchroniser
  task oscEdges(input logic useExt, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (useExt)
        extOscClkIn <= 1'b1;
      else
        intOscClkIn <= 1'b1;
      repeat (4) @(posedge clk);
      extOscClkIn <= 1'b0;
      intOscClkIn <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk); // Let the sync latency drain before counting
  endtask

  // Main sequence
  initial
  begin
    clk = 0; reset = 1; sfrAddr = 0; sfrWrite = 0; sfrWdata = 0; sfrRead = 0;
    intOscClkIn = 0; extOscClkIn = 0; loopLockIn = 0;
    errors = 0; nTests = 0; ticks = 0; cycles = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 checkVal({6'h00, oscRangeField}, 8'h03);
    checkVal({4'h0, loopFilterField}, 8'h01);
    checkVal({7'h00, lockFlag}, 8'h00);
    readCheck(`LOOP_FILTER_CONFIG_ADDR, 8'h31);
    readCheck(`LOOP_CONTROL_ADDR, 8'h00);
    readCheck(`PREDIV_ADDR, 8'h01);
    readCheck(`MULTIPLIER_ADDR, 8'h01);
    wrReg(8'h91, 8'hFF);
    readCheck(8'h91, 8'h00);
    // Every range code, each with one of four filter codes, top bits written high to show they are dropped
    for (int i = 0; i < 4; i++)
    begin
      wrReg(`LOOP_FILTER_CONFIG_ADDR, {2'b11, 2'(i), filterCodes[i]});
      checkVal({6'h00, oscRangeField}, {6'h00, 2'(i)});
      checkVal({4'h0, loopFilterField}, {4'h0, filterCodes[i]});
      readCheck(`LOOP_FILTER_CONFIG_ADDR, {2'b00, 2'(i), filterCodes[i]});
    end
    // Lock bit cannot be written by software
    wrReg(`LOOP_CONTROL_ADDR, 8'h20);
    readCheck(`LOOP_CONTROL_ADDR, 8'h00);
    // Internal reference: divide by 2, pre-divide by 2, so 16 edges give 4 pulses
    wrReg(`INT_OSC_CONTROL_ADDR, 8'h01);
    readCheck(`INT_OSC_CONTROL_ADDR, 8'h01);
    wrReg(`PREDIV_ADDR, 8'h22);
    checkVal({3'b000, predivValue}, 8'h02);
    readCheck(`PREDIV_ADDR, 8'h02);
    base = ticks;
    oscEdges(1'b0, 16);
    checkVal(8'(ticks - base), 8'h04);
    // Every internal divide code with a pre-divider of one: 8 edges give 8 >> code pulses
    for (int d = 0; d < 4; d++)
    begin
      wrReg(`INT_OSC_CONTROL_ADDR, 8'(d));
      wrReg(`PREDIV_ADDR, 8'h01);
      base = ticks;
      oscEdges(1'b0, 8);
      checkVal(8'(ticks - base), 8'(8 >> d));
    end
    // External oscillator is pulsed four times before it becomes the reference
    oscEdges(1'b1, 4);
    wrReg(`LOOP_CONTROL_ADDR, 8'h04);
    checkVal({7'h00, refSourceSelect}, 8'h01);
    wrReg(`PREDIV_ADDR, 8'h03);
    base = ticks;
    oscEdges(1'b0, 16);
    checkVal(8'(ticks - base), 8'h00);
    oscEdges(1'b1, 12);
    checkVal(8'(ticks - base), 8'h04);
    // Pre-divider of zero stands for 32
    wrReg(`PREDIV_ADDR, 8'h00);
    base = ticks;
    oscEdges(1'b1, 31);
    checkVal(8'(ticks - base), 8'h00);
    oscEdges(1'b1, 1);
    checkVal(8'(ticks - base), 8'h01);
    wrReg(`MULTIPLIER_ADDR, 8'h05);
    checkVal(multiplierValue, 8'h05);
    readCheck(`MULTIPLIER_ADDR, 8'h05);
    // Lock acquisition: flag only after the settle time
    @(posedge clk);
    loopLockIn <= 1'b1;
    repeat (90) @(posedge clk);
    #1 checkVal({7'h00, lockFlag}, 8'h00);
    repeat (20) @(posedge clk);
    #1 checkVal({7'h00, lockFlag}, 8'h01);
    readCheck(`LOOP_CONTROL_ADDR, 8'h24);
    // Rewriting the same source keeps lock; a new multiplier drops it
    wrReg(`LOOP_CONTROL_ADDR, 8'h04);
    repeat (2) @(posedge clk);
    #1 checkVal({7'h00, lockFlag}, 8'h01);
    wrReg(`MULTIPLIER_ADDR, 8'h07);
    repeat (2) @(posedge clk);
    #1 checkVal({7'h00, lockFlag}, 8'h00);
    repeat (115) @(posedge clk);
    #1 checkVal({7'h00, lockFlag}, 8'h01);
    // Source change drops lock too
    wrReg(`LOOP_CONTROL_ADDR, 8'h00);
    repeat (2) @(posedge clk);
    #1 checkVal({7'h00, lockFlag}, 8'h00);
    repeat (115) @(posedge clk);
    #1 checkVal({7'h00, lockFlag}, 8'h01);
    @(posedge clk);
    loopLockIn <= 1'b0;
    repeat (6) @(posedge clk);
    #1 checkVal({7'h00, lockFlag}, 8'h00);
    give_verdict;
  end
endmodule
